//--- pkg/css_defs.svh
// Purpose: Constants for the clock source start-up sequencer
// Assumes: Fuse values are held as stored bits, one meaning unprogrammed
// Notes:   Counts are in oscillator or watchdog-oscillator cycles
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH
`define CSS_CNT_W         17
`define CSS_CKSEL_RESET   4'h2
`define CSS_SUT_RESET     2'h2
`define CSS_DIVIDE_BY_EIGHT_OPTION_RESET  1'h0
`define CSS_TOUT_SHORT    17'h00200
`define CSS_TOUT_LONG     17'h02000
`define CSS_SU_EXT        17'h00006
`define CSS_SU_XTAL_SHORT 17'h00102
`define CSS_SU_XTAL_MID   17'h00400
`define CSS_SU_XTAL_LONG  17'h04000
`define CSS_SU_LF         17'h08000
`define CSS_SU_EXTRA      17'h0000e
`define CSS_DIV_LAST      3'h7
`endif

//--- pkg/css_pkg.sv
// Purpose: Types for the clock source start-up sequencer
// Assumes: Used with css_defs.svh
// Notes:   No constants here, only types
package css_pkg;
  typedef enum logic [2:0] {
    CSS_SRC_LP_XTAL  = 3'h0,
    CSS_SRC_FS_XTAL  = 3'h1,
    CSS_SRC_LF_XTAL  = 3'h2,
    CSS_SRC_RC_128K  = 3'h3,
    CSS_SRC_RC_CAL   = 3'h4,
    CSS_SRC_EXT      = 3'h5,
    CSS_SRC_RESERVED = 3'h6
  } css_src_e;
  typedef enum logic [2:0] {
    CSS_LOAD    = 3'h0,
    CSS_HOLD    = 3'h1,
    CSS_TIMEOUT = 3'h2,
    CSS_STARTUP = 3'h3,
    CSS_ALIGN   = 3'h4,
    CSS_RUN     = 3'h5,
    CSS_SLEEP   = 3'h6,
    CSS_WAKE    = 3'h7
  } css_state_e;
  typedef enum logic [1:0] {
    CSS_SLP_IDLE       = 2'h0,
    CSS_SLP_CONV_NOISE = 2'h1,
    CSS_SLP_POWER_SAVE = 2'h2,
    CSS_SLP_POWER_DOWN = 2'h3
  } css_sleep_e;
  typedef struct packed {
    logic [3:0] clock_source_select;
    logic [1:0] startup_time_select;
    logic       divide_by_eight_option;
  } css_fuse_s;
  typedef struct packed {
    logic core_clock;
    logic peripheral_clock;
    logic program_memory_clock;
    logic async_timer_clock;
    logic converter_clock;
  } css_clk_en_s;
endpackage

//--- src/css_startup_sequencer.sv
// Purpose: Clock source decode, reset time-out and start-up sequencing, clock domain gating
// Assumes: Oscillator and watchdog-oscillator cycles arrive as one-cycle ticks on clock
// Notes:   Clock domains leave as enables for the gating cells
`timescale 1ns/1ps
`include "css_defs.svh"
`default_nettype none
module css_startup_sequencer #(
  parameter logic [`CSS_CNT_W-1:0] TOUT_LONG_CYC = `CSS_TOUT_LONG,
  parameter logic [`CSS_CNT_W-1:0] SU_LONG_CYC   = `CSS_SU_XTAL_LONG,
  parameter logic [`CSS_CNT_W-1:0] SU_LF_CYC     = `CSS_SU_LF
) (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire css_pkg::css_fuse_s  fuse_word,
  input  wire logic                fuse_valid,
  input  wire logic                other_reset_active,
  input  wire logic                wdt_osc_tick,
  input  wire logic                osc_tick,
  input  wire logic                sleep_enter,
  input  wire css_pkg::css_sleep_e sleep_mode,
  input  wire logic                wake_event,
  input  wire logic                level_wake,
  input  wire logic                async_source_present,
  output logic                     internal_reset,
  output css_pkg::css_clk_en_s     clock_enables,
  output logic                     system_clock_tick,
  output logic                     level_irq,
  output logic                     config_error,
  output logic                     divide_active
);
  css_pkg::css_fuse_s     cfg_q,       cfg_d;
  css_pkg::css_state_e    state_q,     state_d;
  css_pkg::css_sleep_e    mode_q,      mode_d;
  logic [`CSS_CNT_W-1:0]  cnt_q,       cnt_d;
  logic [2:0]             div_q,       div_d;
  logic                   rst_q,       rst_d;
  css_pkg::css_clk_en_s   en_q,        en_d;
  logic                   tick_q,      tick_d;
  logic                   irq_q,       irq_d;
  logic                   err_q,       err_d;
  logic                   dive_q,      dive_d;
  css_pkg::css_src_e      src_kind;
  logic [`CSS_CNT_W-1:0]  timeout_cyc;
  logic [`CSS_CNT_W-1:0]  startup_cyc;
  logic [`CSS_CNT_W-1:0]  wake_cyc;
  logic                   div8_on;
  logic                   sys_tick_now;
  logic                   sleep_keeps_osc;

  // Fuse decode
  always_comb begin
    div8_on = ~cfg_q.divide_by_eight_option;
    unique casez (cfg_q.clock_source_select)
      4'b1???: src_kind = css_pkg::CSS_SRC_LP_XTAL;
      4'b011?: src_kind = css_pkg::CSS_SRC_FS_XTAL;
      4'b010?: src_kind = css_pkg::CSS_SRC_LF_XTAL;
      4'b0011: src_kind = css_pkg::CSS_SRC_RC_128K;
      4'b0010: src_kind = css_pkg::CSS_SRC_RC_CAL;
      4'b0000: src_kind = css_pkg::CSS_SRC_EXT;
      default: src_kind = css_pkg::CSS_SRC_RESERVED;
    endcase
    timeout_cyc = '0;
    startup_cyc = `CSS_SU_EXT;
    if (src_kind == css_pkg::CSS_SRC_LP_XTAL || src_kind == css_pkg::CSS_SRC_FS_XTAL) begin
      unique case ({cfg_q.clock_source_select[0], cfg_q.startup_time_select})
        3'h0: begin
          startup_cyc = `CSS_SU_XTAL_SHORT + `CSS_SU_EXTRA;
          timeout_cyc = `CSS_TOUT_SHORT;
        end
        3'h1: begin
          startup_cyc = `CSS_SU_XTAL_SHORT + `CSS_SU_EXTRA;
          timeout_cyc = TOUT_LONG_CYC;
        end
        3'h2: begin
          startup_cyc = `CSS_SU_XTAL_MID + `CSS_SU_EXTRA;
          timeout_cyc = '0;
        end
        3'h3: begin
          startup_cyc = `CSS_SU_XTAL_MID + `CSS_SU_EXTRA;
          timeout_cyc = `CSS_TOUT_SHORT;
        end
        3'h4: begin
          startup_cyc = `CSS_SU_XTAL_MID + `CSS_SU_EXTRA;
          timeout_cyc = TOUT_LONG_CYC;
        end
        3'h5: begin
          startup_cyc = SU_LONG_CYC + `CSS_SU_EXTRA;
          timeout_cyc = '0;
        end
        3'h6: begin
          startup_cyc = SU_LONG_CYC + `CSS_SU_EXTRA;
          timeout_cyc = `CSS_TOUT_SHORT;
        end
        3'h7: begin
          startup_cyc = SU_LONG_CYC + `CSS_SU_EXTRA;
          timeout_cyc = TOUT_LONG_CYC;
        end
      endcase
    end else begin
      if (src_kind == css_pkg::CSS_SRC_LF_XTAL || src_kind == css_pkg::CSS_SRC_RESERVED) begin
        startup_cyc = SU_LF_CYC;
      end
      unique case (cfg_q.startup_time_select)
        2'h0: timeout_cyc = '0;
        2'h1: timeout_cyc = `CSS_TOUT_SHORT;
        2'h2: timeout_cyc = TOUT_LONG_CYC;
        2'h3: timeout_cyc = TOUT_LONG_CYC;
      endcase
    end
    wake_cyc = startup_cyc;
    if (src_kind == css_pkg::CSS_SRC_LP_XTAL || src_kind == css_pkg::CSS_SRC_FS_XTAL) begin
      wake_cyc = startup_cyc - `CSS_SU_EXTRA;
    end
  end

  // System clock divider
  always_comb begin
    div_d = div_q;
    sys_tick_now = 1'b0;
    if (osc_tick) begin
      div_d = div_q + 3'h1;
      sys_tick_now = !div8_on || (div_q == `CSS_DIV_LAST);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // Sequencer
  always_comb begin
    cfg_d = cfg_q;
    state_d = state_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    irq_d = 1'b0;
    unique case (state_q)
      css_pkg::CSS_LOAD: begin
        if (fuse_valid) begin
          cfg_d = fuse_word;
          state_d = css_pkg::CSS_HOLD;
        end
      end
      css_pkg::CSS_HOLD: begin
        if (!other_reset_active) begin
          if (timeout_cyc == '0) begin
            state_d = css_pkg::CSS_STARTUP;
            cnt_d = startup_cyc;
          end else begin
            state_d = css_pkg::CSS_TIMEOUT;
            cnt_d = timeout_cyc;
          end
        end
      end
      css_pkg::CSS_TIMEOUT: begin
        if (wdt_osc_tick) begin
          cnt_d = cnt_q - 1'b1;
          if (cnt_q == `CSS_CNT_W'(1)) begin
            state_d = css_pkg::CSS_STARTUP;
            cnt_d = startup_cyc;
          end
        end
      end
      css_pkg::CSS_STARTUP: begin
        if (osc_tick) begin
          cnt_d = cnt_q - 1'b1;
          if (cnt_q == `CSS_CNT_W'(1)) begin
            state_d = css_pkg::CSS_ALIGN;
          end
        end
      end
      css_pkg::CSS_ALIGN: begin
        if (sys_tick_now) begin
          state_d = css_pkg::CSS_RUN;
        end
      end
      css_pkg::CSS_RUN: begin
        if (sleep_enter) begin
          state_d = css_pkg::CSS_SLEEP;
          mode_d = sleep_mode;
        end
      end
      css_pkg::CSS_SLEEP: begin
        if (wake_event || level_wake) begin
          if (mode_q == css_pkg::CSS_SLP_POWER_SAVE || mode_q == css_pkg::CSS_SLP_POWER_DOWN) begin
            state_d = css_pkg::CSS_WAKE;
            cnt_d = wake_cyc;
          end else begin
            state_d = css_pkg::CSS_RUN;
            irq_d = level_wake;
          end
        end
      end
      css_pkg::CSS_WAKE: begin
        if (osc_tick) begin
          cnt_d = cnt_q - 1'b1;
          if (cnt_q == `CSS_CNT_W'(1)) begin
            state_d = css_pkg::CSS_RUN;
            irq_d = level_wake;
          end
        end
      end
    endcase
    if (other_reset_active && state_q != css_pkg::CSS_LOAD) begin
      state_d = css_pkg::CSS_HOLD;
      irq_d = 1'b0;
    end
  end

  // Outputs
  always_comb begin
    sleep_keeps_osc = (mode_d == css_pkg::CSS_SLP_IDLE) || (mode_d == css_pkg::CSS_SLP_CONV_NOISE);
    rst_d = (state_d != css_pkg::CSS_RUN) && (state_d != css_pkg::CSS_SLEEP) && (state_d != css_pkg::CSS_WAKE);
    en_d = '0;
    if (state_d == css_pkg::CSS_RUN) begin
      en_d.core_clock = 1'b1;
      en_d.peripheral_clock = 1'b1;
      en_d.converter_clock = 1'b1;
    end else if (state_d == css_pkg::CSS_SLEEP) begin
      en_d.peripheral_clock = (mode_d == css_pkg::CSS_SLP_IDLE);
      en_d.converter_clock = sleep_keeps_osc;
    end
    en_d.program_memory_clock = en_d.core_clock;
    en_d.async_timer_clock = async_source_present && (state_d == css_pkg::CSS_RUN ||
                             state_d == css_pkg::CSS_WAKE || (state_d == css_pkg::CSS_SLEEP &&
                             mode_d != css_pkg::CSS_SLP_POWER_DOWN));
    tick_d = sys_tick_now;
    err_d = (src_kind == css_pkg::CSS_SRC_RESERVED);
    dive_d = div8_on;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_q <= '{`CSS_CKSEL_RESET, `CSS_SUT_RESET, `CSS_DIVIDE_BY_EIGHT_OPTION_RESET};
      state_q <= css_pkg::CSS_LOAD;
      mode_q <= css_pkg::CSS_SLP_IDLE;
      cnt_q <= '0;
      rst_q <= 1'b1;
      en_q <= '0;
      tick_q <= 1'b0;
      irq_q <= 1'b0;
      err_q <= 1'b0;
      dive_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      state_q <= state_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      rst_q <= rst_d;
      en_q <= en_d;
      tick_q <= tick_d;
      irq_q <= irq_d;
      err_q <= err_d;
      dive_q <= dive_d;
    end
  end

  assign internal_reset = rst_q;
  assign clock_enables = en_q;
  assign system_clock_tick = tick_q;
  assign level_irq = irq_q;
  assign config_error = err_q;
  assign divide_active = dive_q;

  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_reset_held: assert property (
    state_q inside {css_pkg::CSS_LOAD, css_pkg::CSS_HOLD, css_pkg::CSS_TIMEOUT, css_pkg::CSS_STARTUP}
    |-> internal_reset)
    else $error("internal reset not held during sequence");
  a_timeout_load: assert property (
    (state_q == css_pkg::CSS_HOLD && !other_reset_active && timeout_cyc != '0)
    |=> (state_q == css_pkg::CSS_TIMEOUT && cnt_q == $past(timeout_cyc)))
    else $error("time-out not loaded");
  a_timeout_off: assert property (
    (state_q == css_pkg::CSS_HOLD && !other_reset_active && timeout_cyc == '0)
    |=> (state_q == css_pkg::CSS_STARTUP && cnt_q == $past(startup_cyc)))
    else $error("disabled time-out not skipped");
  a_startup_end: assert property (
    (state_q == css_pkg::CSS_STARTUP && osc_tick && cnt_q == `CSS_CNT_W'(1) && !other_reset_active)
    |=> state_q == css_pkg::CSS_ALIGN)
    else $error("start-up count did not finish");
  a_wake_skip: assert property (
    (state_q == css_pkg::CSS_SLEEP) |=> (state_q != css_pkg::CSS_TIMEOUT && state_q != css_pkg::CSS_STARTUP))
    else $error("wake ran the time-out");
  a_sync_release: assert property (
    $fell(internal_reset) |-> (system_clock_tick && $past(state_q) == css_pkg::CSS_ALIGN))
    else $error("reset release not on a system tick");
  a_memory_core: assert property (
    clock_enables.program_memory_clock == clock_enables.core_clock)
    else $error("memory clock differs from core clock");
  a_converter_noise: assert property (
    (state_q == css_pkg::CSS_SLEEP && mode_q == css_pkg::CSS_SLP_CONV_NOISE)
    |-> (clock_enables.converter_clock && !clock_enables.core_clock && !clock_enables.peripheral_clock))
    else $error("converter clock gating wrong in noise sleep");
  a_async_save: assert property (
    (state_q == css_pkg::CSS_SLEEP && mode_q == css_pkg::CSS_SLP_POWER_SAVE)
    |-> clock_enables.async_timer_clock == $past(async_source_present))
    else $error("async timer clock stopped in power-save");
  a_level_lost: assert property (
    (state_q == css_pkg::CSS_WAKE && osc_tick && cnt_q == `CSS_CNT_W'(1) && !level_wake)
    |=> (!level_irq && state_q != css_pkg::CSS_SLEEP))
    else $error("level interrupt raised after level vanished");
  a_fuse_static: assert property (
    (state_q != css_pkg::CSS_LOAD) |=> $stable(cfg_q))
    else $error("configuration changed after load");
  a_lf_startup: assert property (
    (cfg_q.clock_source_select[3:1] == 3'h2) |-> startup_cyc == SU_LF_CYC)
    else $error("low-frequency start-up count wrong");
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench for the clock source start-up sequencer
// Assumes: Ticks are driven as one-cycle pulses two cycles apart
// Notes:   Long counts shortened through parameters 16, 32 and 64
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                 clock;
  logic                 reset;
  css_pkg::css_fuse_s   fuse_word;
  logic                 fuse_valid;
  logic                 other_reset_active;
  logic                 wdt_osc_tick;
  logic                 osc_tick;
  logic                 sleep_enter;
  css_pkg::css_sleep_e  sleep_mode;
  logic                 wake_event;
  logic                 level_wake;
  logic                 async_source_present;
  logic                 internal_reset;
  css_pkg::css_clk_en_s clock_enables;
  logic                 system_clock_tick;
  logic                 level_irq;
  logic                 config_error;
  logic                 divide_active;
  int                   n_fail;
  int                   checks_done;
  int                   irq_seen;
  int                   stick_seen;
  logic [6:0]           fz [10] = '{7'h14, 7'h01, 7'h1b, 7'h27, 7'h09, 7'h41, 7'h35, 7'h7b, 7'h38, 7'h4d};
  int                   tt [10] = '{16, 0, 512, 16, 0, 512, 0, 0, 16, 512};
  int                   ss [10] = '{6, 6, 6, 64, 64, 272, 1038, 46, 1038, 46};

  css_startup_sequencer #(
    .TOUT_LONG_CYC (17'h00010),
    .SU_LONG_CYC   (17'h00020),
    .SU_LF_CYC     (17'h00040)
  ) css_startup_sequencer_inst (
    .clock                (clock),
    .reset                (reset),
    .fuse_word            (fuse_word),
    .fuse_valid           (fuse_valid),
    .other_reset_active   (other_reset_active),
    .wdt_osc_tick         (wdt_osc_tick),
    .osc_tick             (osc_tick),
    .sleep_enter          (sleep_enter),
    .sleep_mode           (sleep_mode),
    .wake_event           (wake_event),
    .level_wake           (level_wake),
    .async_source_present (async_source_present),
    .internal_reset       (internal_reset),
    .clock_enables        (clock_enables),
    .system_clock_tick    (system_clock_tick),
    .level_irq            (level_irq),
    .config_error         (config_error),
    .divide_active        (divide_active)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Pulse counters
  always @(posedge clock) begin
    if (level_irq === 1'b1) irq_seen++;
    if (system_clock_tick === 1'b1) stick_seen++;
  end

  task automatic complete_run;
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_en(input css_pkg::css_clk_en_s got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pulses on the watchdog or oscillator tick
  task automatic tick(input logic wdt, input int n);
    repeat (n) begin
      if (wdt) wdt_osc_tick = 1'b1;
      else osc_tick = 1'b1;
      @(negedge clock);
      wdt_osc_tick = 1'b0;
      osc_tick = 1'b0;
      @(negedge clock);
    end
  endtask

  task automatic do_reset(input logic [6:0] f);
    reset = 1'b1;
    other_reset_active = 1'b1;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    chk_bit(divide_active, 1'b1);
    chk_bit(internal_reset, 1'b1);
    fuse_word = css_pkg::css_fuse_s'(f);
    fuse_valid = 1'b1;
    @(negedge clock);
    fuse_valid = 1'b0;
  endtask

  // Release other resets, run time-out and start-up, wait for release
  task automatic run_startup(input int tout, input int su);
    int k;
    other_reset_active = 1'b0;
    @(negedge clock);
    if (tout > 0) begin
      tick(1'b0, su + 8);
      tick(1'b1, tout - 1);
      tick(1'b0, su + 8);
      chk_bit(internal_reset, 1'b1);
      tick(1'b1, 1);
    end
    tick(1'b0, su - 1);
    chk_bit(internal_reset, 1'b1);
    k = 0;
    while (internal_reset === 1'b1 && k < 10) begin
      tick(1'b0, 1);
      k++;
    end
    if (k >= 10) begin
      n_fail++;
      complete_run();
    end
    chk_bit(logic'(k >= 2), 1'b1);
    chk_en(clock_enables, 5'h1f);
  endtask

  task automatic sleep_wake(input css_pkg::css_sleep_e m, input int su, input logic hold);
    int n0;
    sleep_mode = m;
    sleep_enter = 1'b1;
    @(negedge clock);
    sleep_enter = 1'b0;
    @(negedge clock);
    chk_bit(clock_enables.core_clock, 1'b0);
    chk_bit(clock_enables.program_memory_clock, 1'b0);
    if (m == css_pkg::CSS_SLP_IDLE) chk_bit(clock_enables.peripheral_clock, 1'b1);
    if (m == css_pkg::CSS_SLP_CONV_NOISE) chk_bit(clock_enables.converter_clock, 1'b1);
    if (m == css_pkg::CSS_SLP_CONV_NOISE) chk_bit(clock_enables.peripheral_clock, 1'b0);
    if (m == css_pkg::CSS_SLP_POWER_SAVE) chk_bit(clock_enables.async_timer_clock, 1'b1);
    if (m == css_pkg::CSS_SLP_POWER_DOWN) chk_bit(clock_enables.async_timer_clock, 1'b0);
    n0 = irq_seen;
    level_wake = 1'b1;
    wake_event = 1'b1;
    @(negedge clock);
    wake_event = 1'b0;
    if (!hold) level_wake = 1'b0;
    if (m == css_pkg::CSS_SLP_POWER_SAVE || m == css_pkg::CSS_SLP_POWER_DOWN) begin
      tick(1'b0, su - 1);
      chk_bit(clock_enables.core_clock, 1'b0);
      chk_bit(internal_reset, 1'b0);
      tick(1'b0, 1);
    end
    @(negedge clock);
    chk_en(clock_enables, 5'h1f);
    chk_bit(logic'((irq_seen - n0) == int'(hold)), 1'b1);
    level_wake = 1'b0;
  endtask

  initial begin
    int s0;
    reset = 1'b1;
    fuse_word = '1;
    fuse_valid = 1'b0;
    other_reset_active = 1'b1;
    wdt_osc_tick = 1'b0;
    osc_tick = 1'b0;
    sleep_enter = 1'b0;
    sleep_mode = css_pkg::CSS_SLP_IDLE;
    wake_event = 1'b0;
    level_wake = 1'b0;
    async_source_present = 1'b1;
    n_fail = 0;
    checks_done = 0;
    irq_seen = 0;
    stick_seen = 0;
    @(negedge clock);
    for (int i = 0; i < 10; i++) begin
      do_reset(fz[i]);
      run_startup(tt[i], ss[i]);
      chk_bit(config_error, logic'(i == 4));
      chk_bit(divide_active, ~fz[i][0]);
      s0 = stick_seen;
      tick(1'b0, 16);
      chk_bit(logic'((stick_seen - s0) == (fz[i][0] ? 16 : 2)), 1'b1);
    end
    sleep_wake(css_pkg::CSS_SLP_IDLE, 46, 1'b1);
    sleep_wake(css_pkg::CSS_SLP_CONV_NOISE, 46, 1'b1);
    sleep_wake(css_pkg::CSS_SLP_POWER_SAVE, 32, 1'b1);
    sleep_wake(css_pkg::CSS_SLP_POWER_DOWN, 32, 1'b0);
    fuse_word = css_pkg::css_fuse_s'(7'h01);
    fuse_valid = 1'b1;
    other_reset_active = 1'b1;
    repeat (2) @(negedge clock);
    fuse_valid = 1'b0;
    chk_bit(internal_reset, 1'b1);
    run_startup(512, 46);
    complete_run();
  end
endmodule
`default_nettype wire
